/* hdl/flash_cmd_map.svh */
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

`define CMD_DEV_SEL     8'h10
`define CMD_CLK_SEL     8'h11
`define CMD_INQ_FIRST   8'h20
`define CMD_INQ_LAST    8'h27
`define CMD_NEW_RATE    8'h3F
`define CMD_TO_PE       8'h40
`define CMD_SEL_BOOT    8'h42
`define CMD_SEL_USER    8'h43
`define CMD_SEL_ERASE   8'h48
`define CMD_SUM_BOOT    8'h4A
`define CMD_SUM_USER    8'h4B
`define CMD_BLANK_BOOT  8'h4C
`define CMD_BLANK_USER  8'h4D
`define CMD_PROG        8'h50
`define CMD_READ        8'h52
`define CMD_BLK_ERASE   8'h58

`define RSP_ACK         8'h06
`define RSP_CMD_ERR     8'h80
`define RSP_ERR_FLAG    8'h80

`define ERR_SUM         8'h11
`define ERR_RATE        8'h24
`define ERR_IN_FREQ     8'h25
`define ERR_RATIO       8'h26
`define ERR_OP_FREQ     8'h27
`define ERR_ERASE       8'h51
`define ERR_PROG        8'h53
`define ERR_SELECT      8'h54

`define ADDR_END        32'hFFFF_FFFF
`define BLOCK_END       8'hFF
`define ADDR_BYTES      9'h004
`define DATA_LAST       9'h084
`define PROG_SHORT_LEN  9'h005
`define PROG_LONG_LEN   9'h085
`define PAY_BYTES       9'h007
`define RATIO_COUNT     8'h02

`define FREQ_TO_HZ      48'h0000_0000_2710
`define RATE_TO_DIV     48'h0000_0000_0C80
`define RATE_ERR_RECIP  48'h0000_0000_0019
`define DIV_MAX         48'h0000_0000_0100
`define DIV_MIN         48'h0000_0000_0001

`endif

/* hdl/flash_cmd_pkg.sv */
package flash_cmd_pkg;

	typedef enum logic [8:0] {
		ST_CMD     = 9'b0_0000_0001,
		ST_SIZE    = 9'b0_0000_0010,
		ST_BODY    = 9'b0_0000_0100,
		ST_EVAL    = 9'b0_0000_1000,
		ST_OP      = 9'b0_0001_0000,
		ST_TX0     = 9'b0_0010_0000,
		ST_TX1     = 9'b0_0100_0000,
		ST_BAUD    = 9'b0_1000_0000,
		ST_CONFIRM = 9'b1_0000_0000
	} seq_state_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b001,
		SEL_BOOT = 3'b010,
		SEL_USER = 3'b100
	} prog_area_t;

endpackage : flash_cmd_pkg

/* hdl/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  logic             core_clk,
	input  logic             rst_n,
	input  logic             in_valid,
	input  logic [WIDTH-1:0] in_data,
	output logic             in_ready,
	output logic             out_valid,
	output logic [WIDTH-1:0] out_data,
	input  logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             full;
	logic             empty;

	// The extra pointer bit tells a full buffer from an empty one.
	assign empty     = (wr_ptr == rd_ptr);
	assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge core_clk) begin
		if (in_valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (in_valid && !full) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	chk_fifo_no_overrun: assert property (@(posedge core_clk) disable iff (!rst_n)
		full && !out_ready |=> $stable(wr_ptr))
		else $error("fifo pointer moved while full");
endmodule : byte_fifo

/* hdl/flash_cmd_sequencer.sv */
// Notes on behaviour
// - Operating frequency is input frequency times ratio, or divided; check range. Only main_freq is range-checked here, not peri_freq.
// - Bit rate is refused with a bit-rate error unless its error is below 4%.
// - Error is clock over (divisor+1) times rate times 64 times 2^(2n-1), minus one.
// - Acknowledge at the old rate first, then load the new baud setting.
// - Host confirms at the new rate; the device acknowledges at the new rate.
// - Transition erases user area then boot area, acknowledges, enters programming state.
// - Failed pre-erasure answers the transition error byte and the erasing code.
// - Undefined, misordered or unacceptable commands answer command error plus echo.
// - Clock mode before device, or any inquiry after transition, is a command error.
// - Programming state accepts area selections, 128-byte program, erase and read.
// - Programming state also accepts checksum and blank check for both areas.
// - A program command with the all-ones address ends programming.
// - Boot-area selection loads its routine and acknowledges, else error and code.
// - User-area selection loads the routine steering later data to the user area.
// - User-area selection acknowledges, or returns its error byte and code.
// - A failed bit-rate selection answers an error byte and a specific code.
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module flash_cmd_sequencer
	import flash_cmd_pkg::*;
#(
	parameter logic [15:0] IN_FREQ_MIN = 16'h0320,
	parameter logic [15:0] IN_FREQ_MAX = 16'h0D48,
	parameter logic [15:0] OP_FREQ_MIN = 16'h0320,
	parameter logic [15:0] OP_FREQ_MAX = 16'h1A90,
	parameter logic [7:0]  RATIO_MAX   = 8'h04,
	parameter int          FIFO_DEPTH  = 32
) (
	input  logic        core_clk,
	input  logic        rst_n,
	input  logic        rx_valid,
	input  logic [7:0]  rx_data,
	output logic        rx_ready,
	output logic        tx_valid,
	output logic [7:0]  tx_data,
	input  logic        tx_ready,
	output logic        op_req,
	output logic [7:0]  op_code,
	output logic [31:0] op_addr,
	input  logic        op_done,
	input  logic        op_fail,
	output logic        prog_valid,
	output logic [7:0]  prog_data,
	input  logic        prog_ready,
	output logic        baud_load,
	output logic [1:0]  clock_prescale_select,
	output logic [7:0]  baud_divisor_reg,
	output logic        pe_state
);
	seq_state_t state;
	prog_area_t area;
	logic [7:0]  cmd;
	logic [7:0]  sum;
	logic [8:0]  idx;
	logic [8:0]  len;
	logic [7:0]  pay [7];
	logic [31:0] addr;
	logic [7:0]  tx_next;
	logic        two;
	logic        body;
	logic        bad;
	logic        baud_pend;
	logic        dev_sel;
	logic        clk_sel;
	logic        rate_sel;
	logic        erase_sel;
	logic        cmd_ok;
	logic        in_data;
	logic        take;
	logic        fifo_ready;
	logic [7:0]  fail_code;
	logic        in_ok;
	logic        ratio_ok;
	logic        op_ok;
	logic        rate_found;
	logic [1:0]  next_n;
	logic [7:0]  next_div;
	logic [31:0] main_freq;
	logic [31:0] peri_freq;

	function automatic logic [31:0] scale(input logic [15:0] f, input logic [7:0] r);
		logic [7:0] mag;
		mag = r[7] ? 8'(-r) : r;
		scale = r[7] ? 32'(f) / 32'(mag) : 32'(f) * 32'(mag);
	endfunction : scale

	function automatic logic ratio_fits(input logic [7:0] r);
		logic [7:0] mag;
		mag = r[7] ? 8'(-r) : r;
		ratio_fits = (mag != 8'h00) && (mag <= RATIO_MAX);
	endfunction : ratio_fits

	// Command acceptance depends on which selections the host has completed.
	always_comb begin
		cmd_ok = 1'b0;
		if (!pe_state) begin
			if (rx_data >= `CMD_INQ_FIRST && rx_data <= `CMD_INQ_LAST) begin
				cmd_ok = 1'b1;
			end else if (rx_data == `CMD_DEV_SEL) begin
				cmd_ok = 1'b1;
			end else if (rx_data == `CMD_CLK_SEL) begin
				cmd_ok = dev_sel;
			end else if (rx_data == `CMD_NEW_RATE) begin
				cmd_ok = clk_sel;
			end else if (rx_data == `CMD_TO_PE) begin
				cmd_ok = rate_sel;
			end
		end else begin
			if (rx_data == `CMD_SEL_BOOT || rx_data == `CMD_SEL_USER) begin
				cmd_ok = 1'b1;
			end else if (rx_data == `CMD_SEL_ERASE || rx_data == `CMD_READ) begin
				cmd_ok = 1'b1;
			end else if (rx_data >= `CMD_SUM_BOOT && rx_data <= `CMD_BLANK_USER) begin
				cmd_ok = 1'b1;
			end else if (rx_data == `CMD_PROG) begin
				cmd_ok = (area != SEL_NONE);
			end else if (rx_data == `CMD_BLK_ERASE) begin
				cmd_ok = erase_sel;
			end
		end
	end

	always_comb begin
		if (cmd == `CMD_TO_PE || cmd == `CMD_BLK_ERASE) begin
			fail_code = `ERR_ERASE;
		end else if (cmd == `CMD_PROG) begin
			fail_code = `ERR_PROG;
		end else begin
			fail_code = `ERR_SELECT;
		end
	end

	// Frequency and ratio checks on the new bit-rate packet.
	always_comb begin
		main_freq = scale({pay[2], pay[3]}, pay[5]);
		peri_freq = scale({pay[2], pay[3]}, pay[6]);
		in_ok     = ({pay[2], pay[3]} >= IN_FREQ_MIN) && ({pay[2], pay[3]} <= IN_FREQ_MAX);
		ratio_ok  = (pay[4] == `RATIO_COUNT) && ratio_fits(pay[5]) && ratio_fits(pay[6]);
		op_ok     = (main_freq >= 32'(OP_FREQ_MIN)) && (main_freq <= 32'(OP_FREQ_MAX));
	end

	// Searches prescale settings from the coarsest downward; the smallest fitting one wins.
	// The full-width divide is costly but runs once per selection and keeps the math exact.
	always_comb begin
		logic [47:0] phi;
		logic [47:0] den;
		logic [47:0] q;
		logic [47:0] act;
		logic [47:0] diff;
		den        = '0;
		q          = '0;
		act        = '0;
		diff       = '0;
		phi        = 48'(peri_freq) * `FREQ_TO_HZ;
		rate_found = 1'b0;
		next_n     = 2'h0;
		next_div   = 8'h00;
		for (int i = 3; i >= 0; i--) begin
			den  = (48'({pay[0], pay[1]}) * `RATE_TO_DIV) << (2 * i);
			q    = (den == '0) ? '0 : (phi + (den >> 1)) / den;
			act  = 48'(q * den);
			diff = (phi > act) ? phi - act : act - phi;
			if (q >= `DIV_MIN && q <= `DIV_MAX && 48'(diff * `RATE_ERR_RECIP) < act) begin
				rate_found = 1'b1;
				next_n     = 2'(i);
				next_div   = 8'(q - 1'b1);
			end
		end
	end

	assign in_data = (cmd == `CMD_PROG) && (len == `PROG_LONG_LEN)
		&& (idx >= `ADDR_BYTES) && (idx < `DATA_LAST);
	assign rx_ready = (state == ST_CMD) || (state == ST_SIZE) || (state == ST_CONFIRM)
		|| ((state == ST_BODY) && (!in_data || fifo_ready));
	assign take     = rx_valid && rx_ready;
	assign tx_valid = (state == ST_TX0) || (state == ST_TX1);

	// Program data streams ahead of its checksum; the buffer holds each byte until the executor takes it, which can be before op_req.
	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_prog_fifo (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  ((state == ST_BODY) && in_data && rx_valid),
		.in_data   (rx_data),
		.in_ready  (fifo_ready),
		.out_valid (prog_valid),
		.out_data  (prog_data),
		.out_ready (prog_ready)
	);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state     <= ST_CMD;
			cmd       <= 8'h00;
			sum       <= 8'h00;
			idx       <= 9'h000;
			len       <= 9'h000;
			addr      <= 32'h0000_0000;
			tx_data   <= 8'h00;
			tx_next   <= 8'h00;
			two       <= 1'b0;
			body      <= 1'b0;
			bad       <= 1'b0;
			baud_pend <= 1'b0;
			op_req    <= 1'b0;
			op_code   <= 8'h00;
			op_addr   <= 32'h0000_0000;
			for (int i = 0; i < 7; i++) begin
				pay[i] <= 8'h00;
			end
		end else begin
			op_req <= 1'b0;
			case (state)
			ST_CMD: begin
				if (take) begin
					cmd  <= rx_data;
					sum  <= rx_data;
					idx  <= 9'h000;
					bad  <= !cmd_ok;
					body <= cmd_ok && (rx_data == `CMD_PROG || rx_data == `CMD_DEV_SEL
						|| rx_data == `CMD_CLK_SEL || rx_data == `CMD_NEW_RATE
						|| rx_data == `CMD_READ || rx_data == `CMD_BLK_ERASE);
					len  <= `PROG_SHORT_LEN;
					if (!cmd_ok) begin
						state <= ST_EVAL;
					end else if (rx_data == `CMD_PROG) begin
						state <= ST_BODY;
					end else if (rx_data == `CMD_DEV_SEL || rx_data == `CMD_CLK_SEL
						|| rx_data == `CMD_NEW_RATE || rx_data == `CMD_READ
						|| rx_data == `CMD_BLK_ERASE) begin
						state <= ST_SIZE;
					end else begin
						state <= ST_EVAL;
					end
				end
			end
			ST_SIZE: begin
				if (take) begin
					sum   <= sum + rx_data;
					len   <= 9'(rx_data) + 9'h001;
					state <= ST_BODY;
				end
			end
			ST_BODY: begin
				if (take) begin
					sum <= sum + rx_data;
					idx <= idx + 9'h001;
					if (idx < `PAY_BYTES) begin
						pay[3'(idx)] <= rx_data;
					end
					if (cmd == `CMD_PROG && idx < `ADDR_BYTES) begin
						addr <= {addr[23:0], rx_data};
					end
					if (cmd == `CMD_PROG && idx == `ADDR_BYTES - 9'h001) begin
						len <= ({addr[23:0], rx_data} == `ADDR_END) ? `PROG_SHORT_LEN
							: `PROG_LONG_LEN;
					end
					if (idx == len - 9'h001) begin
						state <= ST_EVAL;
					end
				end
			end
			ST_EVAL: begin
				state   <= ST_TX0;
				two     <= 1'b1;
				tx_next <= cmd;
				op_code <= cmd;
				op_addr <= addr;
				if (bad) begin
					tx_data <= `RSP_CMD_ERR;
				end else if (body && sum != 8'h00) begin
					tx_data <= cmd | `RSP_ERR_FLAG;
					tx_next <= `ERR_SUM;
				end else if (cmd == `CMD_NEW_RATE) begin
					tx_data <= cmd | `RSP_ERR_FLAG;
					if (!in_ok) begin
						tx_next <= `ERR_IN_FREQ;
					end else if (!ratio_ok) begin
						tx_next <= `ERR_RATIO;
					end else if (!op_ok) begin
						tx_next <= `ERR_OP_FREQ;
					end else if (!rate_found) begin
						tx_next <= `ERR_RATE;
					end else begin
						tx_data   <= `RSP_ACK;
						two       <= 1'b0;
						baud_pend <= 1'b1;
					end
				end else if (cmd == `CMD_DEV_SEL || cmd == `CMD_CLK_SEL
					|| (cmd == `CMD_PROG && addr == `ADDR_END)
					|| (cmd == `CMD_BLK_ERASE && pay[0] == `BLOCK_END)) begin
					tx_data <= `RSP_ACK;
					two     <= 1'b0;
				end else begin
					op_req <= 1'b1;
					state  <= ST_OP;
				end
			end
			ST_OP: begin
				if (op_fail) begin
					tx_data <= cmd | `RSP_ERR_FLAG;
					tx_next <= fail_code;
					two     <= 1'b1;
					state   <= ST_TX0;
				end else if (op_done) begin
					tx_data <= `RSP_ACK;
					two     <= 1'b0;
					state   <= ST_TX0;
				end
			end
			ST_TX0: begin
				if (tx_ready) begin
					tx_data <= tx_next;
					if (two) begin
						state <= ST_TX1;
					end else if (baud_pend) begin
						state <= ST_BAUD;
					end else begin
						state <= ST_CMD;
					end
				end
			end
			ST_TX1: begin
				if (tx_ready) begin
					state <= ST_CMD;
				end
			end
			ST_BAUD: begin
				baud_pend <= 1'b0;
				state     <= ST_CONFIRM;
			end
			ST_CONFIRM: begin
				if (take) begin
					tx_data <= (rx_data == `RSP_ACK) ? `RSP_ACK : `RSP_CMD_ERR;
					tx_next <= rx_data;
					two     <= (rx_data != `RSP_ACK);
					state   <= ST_TX0;
				end
			end
			default: state <= ST_CMD;
			endcase
		end
	end

	// Selection progress; dev_sel, clk_sel, rate_sel and pe_state only move forward until a reset, while area and erase_sel can clear.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dev_sel   <= 1'b0;
			clk_sel   <= 1'b0;
			rate_sel  <= 1'b0;
			pe_state  <= 1'b0;
			area      <= SEL_NONE;
			erase_sel <= 1'b0;
		end else if (state == ST_EVAL && !bad && !(body && sum != 8'h00)) begin
			if (cmd == `CMD_DEV_SEL) begin
				dev_sel <= 1'b1;
			end else if (cmd == `CMD_CLK_SEL) begin
				clk_sel <= 1'b1;
			end else if (cmd == `CMD_PROG && addr == `ADDR_END) begin
				area <= SEL_NONE;
			end else if (cmd == `CMD_BLK_ERASE && pay[0] == `BLOCK_END) begin
				erase_sel <= 1'b0;
			end
		end else if (state == ST_BAUD) begin
			rate_sel <= 1'b1;
		end else if (state == ST_OP && op_done && !op_fail) begin
			if (cmd == `CMD_TO_PE) begin
				pe_state <= 1'b1;
			end else if (cmd == `CMD_SEL_BOOT) begin
				area      <= SEL_BOOT;
				erase_sel <= 1'b0;
			end else if (cmd == `CMD_SEL_USER) begin
				area      <= SEL_USER;
				erase_sel <= 1'b0;
			end else if (cmd == `CMD_SEL_ERASE) begin
				erase_sel <= 1'b1;
				area      <= SEL_NONE;
			end
		end
	end

	// The new setting is held back until the acknowledge has left at the old rate.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			baud_load             <= 1'b0;
			clock_prescale_select <= 2'h0;
			baud_divisor_reg      <= 8'h00;
		end else begin
			baud_load <= (state == ST_BAUD);
			if (state == ST_BAUD) begin
				clock_prescale_select <= next_n;
				baud_divisor_reg      <= next_div;
			end
		end
	end

	chk_echo_after_error: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_TX0 && tx_data == `RSP_CMD_ERR && tx_ready |=> tx_data == cmd || !bad)
		else $error("command error not followed by echo");
	chk_baud_after_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(baud_load) |-> $past(state, 2) == ST_TX0 && $past(tx_ready, 2))
		else $error("baud loaded before acknowledge left");
	chk_confirm_reply: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_CONFIRM && rx_valid && rx_data == `RSP_ACK
		|=> state == ST_TX0 && tx_data == `RSP_ACK && !two)
		else $error("confirmation not answered");
	chk_pe_entry: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(pe_state) |-> $past(op_done) && $past(cmd) == `CMD_TO_PE)
		else $error("programming state entered without erasure");
	chk_pe_erase_fail: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_OP && cmd == `CMD_TO_PE && op_fail
		|=> tx_data == (`CMD_TO_PE | `RSP_ERR_FLAG) ##0 tx_next == `ERR_ERASE)
		else $error("erasure failure not reported");
	chk_clock_before_dev: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_CMD && rx_valid && rx_data == `CMD_CLK_SEL && !dev_sel
		|=> ##1 state == ST_TX0 && tx_data == `RSP_CMD_ERR)
		else $error("clock mode before device accepted");
	chk_prog_end: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_EVAL && cmd == `CMD_PROG && !bad && sum == 8'h00 && addr == `ADDR_END
		|=> area == SEL_NONE && tx_data == `RSP_ACK && !op_req)
		else $error("end address did not end programming");
	chk_rate_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_EVAL && cmd == `CMD_NEW_RATE && !bad && sum == 8'h00
		&& in_ok && ratio_ok && op_ok && !rate_found
		|=> tx_data == (`CMD_NEW_RATE | `RSP_ERR_FLAG) && tx_next == `ERR_RATE)
		else $error("bad bit rate not refused");
	chk_sum_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_EVAL && body && !bad && sum != 8'h00
		|=> tx_next == `ERR_SUM && !op_req)
		else $error("checksum error not refused");
	chk_boot_sel_fail: assert property (@(posedge core_clk) disable iff (!rst_n)
		state == ST_OP && cmd == `CMD_SEL_BOOT && op_fail
		|=> tx_data == (`CMD_SEL_BOOT | `RSP_ERR_FLAG) && tx_next == `ERR_SELECT)
		else $error("boot selection failure not reported");
endmodule : flash_cmd_sequencer

/* verif/flash_exec_model.sv */
`timescale 1ns/1ps
// Executor and program-data sink standing behind the sequencer.
module flash_exec_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       op_req,
	input  wire logic       fail,
	input  wire logic [3:0] lat,
	input  wire logic       prog_valid,
	input  wire logic [7:0] prog_data,
	output logic            prog_ready,
	output logic            op_done,
	output logic            op_fail
);
	logic [3:0] cnt;
	logic [1:0] phase;
	logic [7:0] rec [0:127];
	int         n_rec;

	// Latency must be at least one, or a request is never answered.
	always_ff @(posedge core_clk) begin
		op_done <= 1'b0;
		op_fail <= 1'b0;
		if (!rst_n) begin
			cnt <= 4'h0;
		end else if (op_req) begin
			cnt <= lat;
		end else if (cnt == 4'h1) begin
			op_done <= !fail;
			op_fail <= fail;
			cnt     <= 4'h0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end

	// Taking one byte in four lets the buffer fill while the host keeps sending.
	always_ff @(posedge core_clk) begin
		prog_ready <= (phase == 2'h0) && rst_n;
		if (!rst_n) begin
			phase <= 2'h0;
			n_rec <= 0;
		end else begin
			phase <= phase + 2'h1;
			if (prog_valid && prog_ready) begin
				rec[n_rec[6:0]] <= prog_data;
				n_rec           <= n_rec + 1;
			end
		end
	end
endmodule : flash_exec_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic        core_clk;
	logic        rst_n;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_ready;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_ready;
	logic        op_req;
	logic [7:0]  op_code;
	logic [31:0] op_addr;
	logic        op_done;
	logic        op_fail;
	logic        prog_valid;
	logic [7:0]  prog_data;
	logic        prog_ready;
	logic        baud_load;
	logic [1:0]  clock_prescale_select;
	logic [7:0]  baud_divisor_reg;
	logic        pe_state;
	logic        fail;
	logic [3:0]  lat;
	logic [7:0]  last_code;
	logic [31:0] last_addr;
	int          n_errors;
	int          comparisons;
	int          n_load;
	int          n_req;
	int          stalls;

	flash_cmd_sequencer u_flash_cmd_sequencer (
		.core_clk(core_clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.op_req(op_req), .op_code(op_code), .op_addr(op_addr), .op_done(op_done),
		.op_fail(op_fail), .prog_valid(prog_valid), .prog_data(prog_data),
		.prog_ready(prog_ready), .baud_load(baud_load),
		.clock_prescale_select(clock_prescale_select),
		.baud_divisor_reg(baud_divisor_reg), .pe_state(pe_state));

	flash_exec_model u_flash_exec_model (
		.core_clk(core_clk), .rst_n(rst_n), .op_req(op_req), .fail(fail), .lat(lat),
		.prog_valid(prog_valid), .prog_data(prog_data), .prog_ready(prog_ready),
		.op_done(op_done), .op_fail(op_fail));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (baud_load === 1'b1) n_load++;
		if (op_req === 1'b1) begin
			n_req++;
			last_code = op_code;
			last_addr = op_addr;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Byte is held until the edge that finds rx_ready high; refusals are counted.
	task automatic send(input logic [7:0] b);
		int i;
		rx_valid = 1'b1;
		rx_data  = b;
		i = 0;
		while (rx_ready !== 1'b1 && i < 400) begin
			@(posedge core_clk);
			#1;
			i++;
			stalls++;
		end
		chk(i < 400, 1);
		@(posedge core_clk);
		#1;
	endtask : send

	task automatic recv(input logic [7:0] exp);
		int i;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
		i = 0;
		while (tx_valid !== 1'b1 && i < 400) begin
			@(posedge core_clk);
			#1;
			i++;
		end
		chk(i < 400, 1);
		chk(tx_data, exp);
		@(posedge core_clk);
		#1;
	endtask : recv

	task automatic pkt(input logic [7:0] q[$], input logic bad);
		logic [7:0] s;
		s = 8'h00;
		foreach (q[k]) begin
			s = s + q[k];
			send(q[k]);
		end
		send((8'h00 - s) ^ {7'h00, bad});
	endtask : pkt

	task automatic rate_pkt(input logic [15:0] r, input logic [15:0] f, input logic [7:0] m,
			input logic bad);
		pkt('{8'h3F, 8'h07, r[15:8], r[7:0], f[15:8], f[7:0], 8'h02, m, 8'h02}, bad);
	endtask : rate_pkt

	task automatic t_order;
		send(8'h11); recv(8'h80); recv(8'h11);
		send(8'h99); recv(8'h80); recv(8'h99);
		send(8'h40); recv(8'h80); recv(8'h40);
	endtask : t_order

	task automatic t_select;
		lat = 4'h1;
		send(8'h20); recv(8'h06);
		pkt('{8'h10, 8'h04, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b0); recv(8'h06);
		send(8'h21); recv(8'h06);
		pkt('{8'h11, 8'h01, 8'h00}, 1'b0); recv(8'h06);
		for (logic [7:0] c = 8'h22; c <= 8'h27; c++) begin
			send(c); recv(8'h06);
			chk(last_code, c);
		end
	endtask : t_select

	task automatic t_rate;
		rate_pkt(16'h0060, 16'h0064, 8'h02, 1'b0); recv(8'hBF); recv(8'h25);
		rate_pkt(16'h0060, 16'h07D0, 8'h05, 1'b0); recv(8'hBF); recv(8'h26);
		rate_pkt(16'h0060, 16'h07D0, 8'h02, 1'b1); recv(8'hBF); recv(8'h11);
		rate_pkt(16'h0060, 16'h07D0, 8'h04, 1'b0); recv(8'hBF); recv(8'h27);
		rate_pkt(16'h1388, 16'h07D0, 8'h02, 1'b0); recv(8'hBF); recv(8'h24);
		tx_ready = 1'b0;
		rate_pkt(16'h0060, 16'h07D0, 8'h02, 1'b0);
		rx_valid = 1'b0;
		repeat (5) @(posedge core_clk);
		#1;
		chk(tx_valid, 1'b1);
		chk(n_load, 0);
		recv(8'h06);
		repeat (3) @(posedge core_clk);
		#1;
		chk(n_load, 1);
		chk(clock_prescale_select, 2'h0);
		chk(baud_divisor_reg, 8'h81);
		send(8'h06); recv(8'h06);
	endtask : t_rate

	task automatic t_pe;
		fail = 1'b1;
		send(8'h40); recv(8'hC0); recv(8'h51);
		chk(pe_state, 1'b0);
		fail = 1'b0;
		lat  = 4'hC;
		send(8'h40); recv(8'h06);
		chk(last_code, 8'h40);
		chk(pe_state, 1'b1);
		send(8'h20); recv(8'h80); recv(8'h20);
		send(8'h50); recv(8'h80); recv(8'h50);
	endtask : t_pe

	task automatic t_sel;
		fail = 1'b1;
		send(8'h42); recv(8'hC2); recv(8'h54);
		fail = 1'b0;
		send(8'h43); recv(8'h06);
		chk(last_code, 8'h43);
	endtask : t_sel

	// The buffer holds only a quarter of a chunk, so the slow sink must force refusals.
	task automatic t_prog;
		logic [7:0] q[$];
		int         i;
		int         bad;
		q = '{8'h50, 8'h00, 8'h00, 8'h01, 8'h00};
		for (int k = 0; k < 128; k++) q.push_back(k[7:0] ^ 8'h5A);
		stalls = 0;
		pkt(q, 1'b0); recv(8'h06);
		chk(last_code, 8'h50);
		chk(last_addr, 32'h0000_0100);
		chk(stalls > 0, 1);
		i = 0;
		while (u_flash_exec_model.n_rec < 128 && i < 400) begin
			@(posedge core_clk);
			#1;
			i++;
		end
		bad = 0;
		for (int k = 0; k < 128; k++) begin
			if (u_flash_exec_model.rec[k] !== (k[7:0] ^ 8'h5A)) bad++;
		end
		chk(bad, 0);
		chk(prog_valid, 1'b0);
		i = n_req;
		pkt('{8'h50, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, 1'b0); recv(8'h06);
		chk(n_req, i);
		send(8'h50); recv(8'h80); recv(8'h50);
		send(8'h42); recv(8'h06);
		chk(last_code, 8'h42);
	endtask : t_prog

	// Erase selection arms block erasure; block number FF disarms it without an operation.
	task automatic t_erase;
		int n;
		fail = 1'b0;
		send(8'h48); recv(8'h06);
		pkt('{8'h58, 8'h01, 8'h03}, 1'b0); recv(8'h06);
		chk(last_code, 8'h58);
		n = n_req;
		pkt('{8'h58, 8'h01, 8'hFF}, 1'b0); recv(8'h06);
		chk(n_req, n);
		send(8'h58); recv(8'h80); recv(8'h58);
		pkt('{8'h52, 8'h09, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10},
			1'b0); recv(8'h06);
		chk(last_code, 8'h52);
	endtask : t_erase

	task automatic t_fwd;
		fail = 1'b1;
		lat  = 4'h1;
		for (logic [7:0] c = 8'h4A; c <= 8'h4D; c++) begin
			send(c); recv(c | 8'h80); recv(8'h54);
		end
	endtask : t_fwd

	task automatic results;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	initial begin
		#500000;
		n_errors++;
		results();
	end

	initial begin
		rst_n       = 1'b0;
		rx_valid    = 1'b0;
		rx_data     = 8'h00;
		tx_ready    = 1'b1;
		fail        = 1'b0;
		lat         = 4'h3;
		n_errors    = 0;
		comparisons = 0;
		n_load      = 0;
		n_req       = 0;
		stalls      = 0;
		repeat (10) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		t_order();
		t_select();
		t_rate();
		t_pe();
		t_sel();
		t_prog();
		t_erase();
		t_fwd();
		results();
	end
endmodule : tb_top
